// File: rtl/gdo_port.sv
/*
 * eight-line general-purpose port: drive enable, drive level, sampled
 * levels and per-line event flags behind a plain register port.
 * assumes pins are asynchronous and software obeys one-cycle strobes.
 */
// Added by the designer: the address-and-strobe port.
// Function
// - enable-clear one bit clears drive enable
// - enable-toggle one bit inverts drive enable
// - enable strobes read back drive enable
// - zero strobe bits leave bits unchanged
// - strobes change selected bits in one write
// - level drives line only when enabled
// - drive level has eight bits, one per line
// - level-set one bit sets drive level
// - level-clear one bit clears drive level
// - level-toggle or sampled write inverts level
// - level strobes read back drive level
// - sampled levels follow enabled line state
// - sampled bit one high, zero low
// - disabled buffer holds sampled bit
// - enable zero input only, one output
// - events set flags; one clears flag
// - sense code four disables input buffer
`include "gdo_params.svh"
`timescale 1ns/10ps
`default_nettype none

module gdo_port #(
    parameter int NL = 8
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // register port
    input  wire gdo_pkg::gdo_req_t   req,
    output logic [7:0]               rdata,
    // pins
    input  wire logic [NL-1:0]       pin_level,
    output gdo_pkg::gdo_pad_t        pad,
    // line events and flags
    output logic [NL-1:0]            line_event,
    output logic [NL-1:0]            evt_flags
);
    logic [NL-1:0]   drv_en_q;
    logic [NL-1:0]   drv_lvl_q;
    logic [NL-1:0]   samp_q;
    logic [NL-1:0]   evt_q;
    logic [3*NL-1:0] sense_q;
    logic [NL-1:0]   s1_q;
    logic [NL-1:0]   s2_q;
    logic [NL-1:0]   s3_q;
    logic [NL-1:0]   buf_en;
    logic [NL-1:0]   hit;
    logic [7:0]      rdata_q;

    function automatic logic wr_at(input gdo_pkg::gdo_req_t r,
                                   input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    function automatic logic [7:0] pad8(input logic [NL-1:0] v);
        logic [7:0] t;
        t = 8'h00;
        t[NL-1:0] = v;
        return t;
    endfunction

    // drive enable register and its strobes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            drv_en_q <= NL'(`GDO_RST_BYTE);
        end else if (wr_at(req, `GDO_OFS_DRV_EN)) begin
            drv_en_q <= req.wdata[NL-1:0];
        end else if (wr_at(req, `GDO_OFS_DRV_EN_SET)) begin
            drv_en_q <= drv_en_q | req.wdata[NL-1:0];
        end else if (wr_at(req, `GDO_OFS_DRV_EN_CLR)) begin
            drv_en_q <= drv_en_q & ~req.wdata[NL-1:0];
        end else if (wr_at(req, `GDO_OFS_DRV_EN_TGL)) begin
            drv_en_q <= drv_en_q ^ req.wdata[NL-1:0];
        end
    end

    // drive level register and its strobes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            drv_lvl_q <= NL'(`GDO_RST_BYTE);
        end else if (wr_at(req, `GDO_OFS_DRV_LVL)) begin
            drv_lvl_q <= req.wdata[NL-1:0];
        end else if (wr_at(req, `GDO_OFS_DRV_LVL_SET)) begin
            drv_lvl_q <= drv_lvl_q | req.wdata[NL-1:0];
        end else if (wr_at(req, `GDO_OFS_DRV_LVL_CLR)) begin
            drv_lvl_q <= drv_lvl_q & ~req.wdata[NL-1:0];
        end else if (wr_at(req, `GDO_OFS_DRV_LVL_TGL)
                     || wr_at(req, `GDO_OFS_SAMPLED)) begin
            drv_lvl_q <= drv_lvl_q ^ req.wdata[NL-1:0];
        end
    end

    // sense configuration, three bits per line
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sense_q <= (3*NL)'(`GDO_RST_SENSE);
        end else if (wr_at(req, `GDO_OFS_SENSE_LO)) begin
            sense_q[3*NL-1:0] <= {sense_q[3*NL-1:12],
                                  req.wdata[6:4], req.wdata[2:0],
                                  sense_q[5:0]};
        end else if (wr_at(req, `GDO_OFS_SENSE_HI)) begin
            sense_q[5:0] <= {req.wdata[6:4], req.wdata[2:0]};
        end
    end

    // line synchroniser, three stages
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_level;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // buffer enable and event match
    always_comb begin
        for (int i = 0; i < NL; i++) begin
            buf_en[i] = sense_q[3*i +: 3]
                        != 3'(gdo_pkg::GDO_SC_IN_OFF);
            unique case (sense_q[3*i +: 3])
                3'(gdo_pkg::GDO_SC_BOTH): hit[i] = s2_q[i] ^ s3_q[i];
                3'(gdo_pkg::GDO_SC_RISE): hit[i] = s2_q[i] & ~s3_q[i];
                3'(gdo_pkg::GDO_SC_FALL): hit[i] = ~s2_q[i] & s3_q[i];
                3'(gdo_pkg::GDO_SC_LOW):  hit[i] = ~s2_q[i] & ~s3_q[i];
                default:                  hit[i] = 1'b0;
            endcase
        end
    end

    // sampled levels update only while buffer is on
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            samp_q <= NL'(`GDO_RST_BYTE);
        end else begin
            for (int i = 0; i < NL; i++) begin
                if (buf_en[i] && s2_q[i] == s3_q[i]) begin
                    samp_q[i] <= s3_q[i];
                end
            end
        end
    end

    // event flags: set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            evt_q <= NL'(`GDO_RST_BYTE);
        end else if (wr_at(req, `GDO_OFS_EVT_FLAGS)) begin
            evt_q <= (evt_q & ~req.wdata[NL-1:0]) | (hit & buf_en);
        end else begin
            evt_q <= evt_q | (hit & buf_en);
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= `GDO_RST_BYTE;
        end else if (req.rd) begin
            unique case (req.addr)
                `GDO_OFS_DRV_EN, `GDO_OFS_DRV_EN_SET,
                `GDO_OFS_DRV_EN_CLR, `GDO_OFS_DRV_EN_TGL:
                    rdata_q <= pad8(drv_en_q);
                `GDO_OFS_DRV_LVL, `GDO_OFS_DRV_LVL_SET,
                `GDO_OFS_DRV_LVL_CLR, `GDO_OFS_DRV_LVL_TGL:
                    rdata_q <= pad8(drv_lvl_q);
                `GDO_OFS_SAMPLED:   rdata_q <= pad8(samp_q);
                `GDO_OFS_EVT_FLAGS: rdata_q <= pad8(evt_q);
                `GDO_OFS_SENSE_LO:
                    rdata_q <= {1'b0, sense_q[5:3], 1'b0, sense_q[2:0]};
                `GDO_OFS_SENSE_HI:
                    rdata_q <= {1'b0, sense_q[5:3], 1'b0, sense_q[2:0]};
                default:            rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata      = rdata_q;
    assign pad.oe     = pad8(drv_en_q);
    assign pad.o      = pad8(drv_lvl_q & drv_en_q);
    assign line_event = s3_q & buf_en;
    assign evt_flags  = evt_q;

    // checks
    en_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_DRV_EN_CLR) |=>
        (drv_en_q == ($past(drv_en_q) & ~$past(req.wdata[NL-1:0]))))
        else $error("enable clear wrong");
    en_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_DRV_EN_TGL) |=>
        (drv_en_q == ($past(drv_en_q) ^ $past(req.wdata[NL-1:0]))))
        else $error("enable toggle wrong");
    en_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.rd && req.addr == `GDO_OFS_DRV_EN_CLR) |=>
        (rdata == pad8($past(drv_en_q))))
        else $error("enable readback wrong");
    lvl_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_DRV_LVL_SET) |=>
        (drv_lvl_q == ($past(drv_lvl_q) | $past(req.wdata[NL-1:0]))))
        else $error("level set wrong");
    lvl_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_DRV_LVL_CLR) |=>
        (drv_lvl_q == ($past(drv_lvl_q) & ~$past(req.wdata[NL-1:0]))))
        else $error("level clear wrong");
    samp_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_SAMPLED) |=>
        (drv_lvl_q == ($past(drv_lvl_q) ^ $past(req.wdata[NL-1:0]))))
        else $error("sampled write toggle wrong");
    lvl_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.rd && req.addr == `GDO_OFS_DRV_LVL_TGL) |=>
        (rdata == pad8($past(drv_lvl_q))))
        else $error("level readback wrong");
    pad_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pad.oe == drv_en_q) && ((pad.o & ~drv_en_q) == '0))
        else $error("pad drive wrong");
    samp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !buf_en[0] |=> (samp_q[0] == $past(samp_q[0])))
        else $error("sampled bit changed while off");
    samp_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (buf_en[0] && s2_q[0] == s3_q[0]) |=> (samp_q[0] == $past(s3_q[0])))
        else $error("sampled bit not updated");
    flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hit[0] && buf_en[0]) |=> evt_q[0])
        else $error("event flag not set");
    en_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_DRV_EN_SET) |=>
        (drv_en_q == ($past(drv_en_q) | $past(req.wdata[NL-1:0]))))
        else $error("enable set wrong");
    lvl_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_DRV_LVL_TGL) |=>
        (drv_lvl_q == ($past(drv_lvl_q) ^ $past(req.wdata[NL-1:0]))))
        else $error("level toggle wrong");
    lvl_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_at(req, `GDO_OFS_DRV_LVL) |=>
        (drv_lvl_q == $past(req.wdata[NL-1:0])))
        else $error("level write wrong");
    samp_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.rd && req.addr == `GDO_OFS_SAMPLED) |=>
        (rdata == pad8($past(samp_q))))
        else $error("sampled readback wrong");
    oe_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pad.oe == pad8(drv_en_q))
        else $error("output enable wrong");
    evt_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !buf_en[0] |-> !line_event[0])
        else $error("line event while buffer off");
    sync_stage_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s2_q == $past(s1_q)) && (s3_q == $past(s2_q)))
        else $error("synchroniser stage wrong");
    flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_at(req, `GDO_OFS_EVT_FLAGS) && req.wdata[0]
         && !(hit[0] && buf_en[0])) |=> !evt_q[0])
        else $error("event flag not cleared");
    flag_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (evt_q[0] && !(wr_at(req, `GDO_OFS_EVT_FLAGS) && req.wdata[0]))
        |=> evt_q[0])
        else $error("event flag lost");
    rd_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !req.rd |=> (rdata == 8'h00))
        else $error("read data not idle");

    // per-line hold and flag checks
    for (genvar g = 0; g < NL; g++) begin : g_line
        line_hold_a: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            !buf_en[g] |=> (samp_q[g] == $past(samp_q[g])))
            else $error("sampled line changed while off");
        line_flag_a: assert property (@(posedge ref_clk)
            disable iff (!rst_n)
            (hit[g] && buf_en[g]) |=> evt_q[g])
            else $error("line flag not set");
    end

    cov_off_c: cover property (@(posedge ref_clk) !buf_en[0]);
    cov_toggle_c: cover property (@(posedge ref_clk)
        wr_at(req, `GDO_OFS_DRV_LVL_TGL));
    cov_flag_c: cover property (@(posedge ref_clk) hit[0] && buf_en[0]);
    cov_clear_c: cover property (@(posedge ref_clk)
        wr_at(req, `GDO_OFS_EVT_FLAGS) && evt_q != '0);
endmodule

`default_nettype wire

// File: rtl/gdo_params.svh
/*
 * register offsets and reset values of the eight-line port.
 * assumes byte-wide registers at the printed offsets on a plain port.
 */
`ifndef GDO_PARAMS_SVH
`define GDO_PARAMS_SVH

`define GDO_OFS_DRV_EN        4'h0
`define GDO_OFS_DRV_EN_SET    4'h1
`define GDO_OFS_DRV_EN_CLR    4'h2
`define GDO_OFS_DRV_EN_TGL    4'h3
`define GDO_OFS_DRV_LVL       4'h4
`define GDO_OFS_DRV_LVL_SET   4'h5
`define GDO_OFS_DRV_LVL_CLR   4'h6
`define GDO_OFS_DRV_LVL_TGL   4'h7
`define GDO_OFS_SAMPLED       4'h8
`define GDO_OFS_EVT_FLAGS     4'h9
`define GDO_OFS_SENSE_LO      4'hA
`define GDO_OFS_SENSE_HI      4'hB
`define GDO_RST_BYTE          8'h00
`define GDO_RST_SENSE         24'h000000

`endif

// File: rtl/gdo_pkg.sv
/*
 * types shared by the port logic.
 * assumes the constants header for numeric values.
 */
package gdo_pkg;
    typedef enum logic [2:0] {
        GDO_SC_NOINT   = 3'h0,
        GDO_SC_BOTH    = 3'h1,
        GDO_SC_RISE    = 3'h2,
        GDO_SC_FALL    = 3'h3,
        GDO_SC_IN_OFF  = 3'h4,
        GDO_SC_LOW     = 3'h5
    } gdo_sense_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } gdo_req_t;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] o;
    } gdo_pad_t;
endpackage

// File: dv/gdo_line_model.sv
/*
 * far-side circuitry on the eight lines: resolves each wire level.
 * assumes outside parts drive ext weakly; an enabled driver wins.
 */
`timescale 1ns/10ps
`default_nettype none

module gdo_line_model (
    // pins from the port
    input  wire gdo_pkg::gdo_pad_t pad,
    // outside levels
    input  wire logic [7:0]        ext,
    // resolved wire levels
    output logic [7:0]             line
);
    // enabled driver overrides the outside level
    assign line = (pad.oe & pad.o) | (~pad.oe & ext);
endmodule

`default_nettype wire

// File: dv/tb_gpio_direction_output_input.sv
/*
 * self-checking bench for the eight-line port.
 * assumes the port answers reads one cycle after the strobe.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_gpio_direction_output_input;
    logic              ref_clk;
    logic              rst_n;
    gdo_pkg::gdo_req_t req;
    gdo_pkg::gdo_pad_t pad;
    logic [7:0]        rdata, pin_level, ext, line_event, evt_flags;
    logic [7:0]        en, lvl, r, d;
    logic [3:0]        a, a2;
    logic              old;
    int                n_errors, checks, cyc;

    gdo_port #(.NL(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
        .rdata(rdata), .pin_level(pin_level), .pad(pad),
        .line_event(line_event), .evt_flags(evt_flags));
    gdo_line_model pins (.pad(pad), .ext(ext), .line(pin_level));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
        @(posedge ref_clk) req <= '{1'b1, 1'b0, ad, dt};
        @(posedge ref_clk) req <= '0;
    endtask

    task automatic rd(input logic [3:0] ad, output logic [7:0] dt);
        @(posedge ref_clk) req <= '{1'b0, 1'b1, ad, 8'h00};
        @(posedge ref_clk) req <= '0;
        #1 dt = rdata;
    endtask

    // expected enable and level after one write
    function automatic logic [15:0] step(logic [7:0] e, logic [7:0] l,
                                         logic [3:0] ad, logic [7:0] dt);
        case (ad)
            4'h0: e = dt;
            4'h1: e = e | dt;
            4'h2: e = e & ~dt;
            4'h3: e = e ^ dt;
            4'h4: l = dt;
            4'h5: l = l | dt;
            4'h6: l = l & ~dt;
            4'h7, 4'h8: l = l ^ dt;
            default: ;
        endcase
        return {e, l};
    endfunction

    task automatic stop_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        req = '0;
        ext = 8'h00;
        en = 8'h00;
        lvl = 8'h00;
        void'($urandom(27));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(4'(i), r);
            chk(r, 8'h00, "reset value");
        end
        // zero writes to offsets 0 to 8, then random writes with readback
        for (int i = 0; i < 260; i++) begin
            a = (i < 9) ? 4'(i) : 4'($urandom % 9);
            d = (i < 9) ? 8'h00 : 8'($urandom);
            wr(a, d);
            {en, lvl} = step(en, lvl, a, d);
            a2 = 4'($urandom % 8);
            rd(a2, r);
            chk(r, (a2 < 4) ? en : lvl, "strobe readback");
            chk(pad.oe, en, "drive enable");
            chk(pad.o, lvl & en, "drive level");
        end
        wr(4'h0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) ext <= 8'($urandom);
            repeat (5) @(posedge ref_clk);
            rd(4'h8, r);
            chk(r, ext, "sampled levels");
            chk(line_event, ext, "line event");
        end
        wr(4'h0, 8'hFF);
        wr(4'h4, 8'hA5);
        repeat (5) @(posedge ref_clk);
        rd(4'h8, r);
        chk(r, 8'hA5, "sampled driven");
        wr(4'h0, 8'h00);
        repeat (5) @(posedge ref_clk);
        wr(4'hB, 8'h04);
        old = ext[0];
        @(posedge ref_clk) ext[0] <= ~old;
        repeat (5) @(posedge ref_clk);
        rd(4'h8, r);
        chk({7'h00, r[0]}, {7'h00, old}, "buffer off hold");
        chk({7'h00, line_event[0]}, 8'h00, "event off");
        @(posedge ref_clk) ext[0] <= 1'b0;
        wr(4'hB, 8'h02);
        repeat (5) @(posedge ref_clk);
        wr(4'h9, 8'hFF);
        @(posedge ref_clk) ext[0] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(4'h9, r);
        chk(r, 8'h01, "rise flag");
        wr(4'h9, 8'h00);
        #1 chk(evt_flags, 8'h01, "zero keeps flag");
        wr(4'h9, 8'h01);
        #1 chk(evt_flags, 8'h00, "one clears flag");
        wr(4'hF, 8'hFF);
        rd(4'hF, r);
        chk(r, 8'h00, "unmapped read");
        chk(pad.oe, 8'h00, "unmapped write");
        stop_test();
    end
endmodule

`default_nettype wire
